//--- pkg/swsc_pkg.sv
// Constants and types for the switch status and sequencer configuration bank.
// Functional notes
// RULE1: Bits 0 and 1 of the switch status word show the live left and right switch levels, 1 meaning active.
// RULE2: Bits 2 and 3 are left and right latch-ready flags set by a configured capture and cleared by reading the status word.
// RULE3: Bits 4 and 5 show a currently active left or right switch stop and are not cleared by reading.
// RULE4: Bit 6 is set by a stall stop event and cleared by reading the status word.
// RULE5: The two low bits of the sequencer mode select 8192, 4096, 8 or 4 table entries, with 8192 after reset.
// RULE6: The sequencer strides through the table so that one electrical period holds the selected length, a quarter of it per full step.
// RULE7: Micro-step progression halts while bit 8 of the sequencer mode is set.
// RULE8: Current control bits 4..0 and 7 give run current and run decay mix, bits 12..8 and 15 the idle ones.
// RULE9: A read-only stall reading and a write-only stall threshold, each ranging 0 to 7, are provided.
// RULE10: Driver status reads back shutdown in bit 0, over-temperature warning in bit 1 and stall in bit 2.
// RULE11: The chopper divider never holds a value below 96 whatever the host writes.
// RULE12: The chopper clock is derived from a write-only divider whose reset value is 640.
// RULE13: A current scale of 16 gives full amplitude, smaller values scale in sixteenths and 0 disables the outputs.
// RULE14: When enabled, a left switch going active captures the ramp position and sets the left latch-ready flag.
// RULE15: Reserved addresses in the sequencer range ignore writes and read as zero.
`default_nettype none
package swsc_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam logic [6:0] ADDR_SWITCH_STATE = 7'h41;
    localparam logic [6:0] ADDR_SEQ_CONFIG = 7'h54;
    localparam logic [6:0] ADDR_COIL_SCALE = 7'h55;
    localparam logic [6:0] ADDR_STALL_READ = 7'h56;
    localparam logic [6:0] ADDR_DRV_FLAGS = 7'h57;
    localparam logic [6:0] ADDR_CHOP_DIV = 7'h59;
    localparam int SW_LIVE_L = 0;
    localparam int SW_LIVE_R = 1;
    localparam int SW_LATCH_L = 2;
    localparam int SW_LATCH_R = 3;
    localparam int SW_STOP_L = 4;
    localparam int SW_STOP_R = 5;
    localparam int SW_STALL = 6;
    localparam int SEQ_W = 9;
    localparam int SEQ_HALT_BIT = 8;
    localparam logic [8:0] SEQ_RESET = 9'h000;
    localparam int COIL_W = 24;
    localparam logic [23:0] COIL_RESET = 24'h000090;
    localparam int RUN_CUR_LSB = 0;
    localparam int RUN_MIX_BIT = 7;
    localparam int IDLE_CUR_LSB = 8;
    localparam int IDLE_MIX_BIT = 15;
    localparam int CUR_W = 5;
    localparam int THR_LSB = 16;
    localparam int THR_W = 3;
    localparam logic [2:0] THR_RESET = 3'h0;
    localparam logic [4:0] CUR_FULL = 5'h10;
    localparam int DIV_W = 11;
    localparam logic [10:0] DIV_RESET = 11'h280;
    localparam logic [10:0] DIV_MIN = 11'h060;
    localparam int IDX_W = 13;
    localparam int AMP_W = 12;
    typedef enum logic [1:0]
    {
        LEN_8192 = 2'b00,
        LEN_4096 = 2'b01,
        LEN_8 = 2'b10,
        LEN_4 = 2'b11
    } swsc_len_e;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [31:0] wdata;
    } swsc_req_s;
    typedef struct packed
    {
        logic valid;
        logic [31:0] rdata;
    } swsc_rsp_s;
endpackage
`default_nettype wire

//--- rtl/swsc_sync.sv
// Two-stage synchroniser for the reference switch pins.
`default_nettype none
module swsc_sync
(
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Asynchronous pins and their synchronised levels
    input wire logic [1:0] async_i,
    output logic [1:0] sync_o
);
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;

    // The first stage feeds only the second stage to keep metastability out.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
        end
        else if (ce_i)
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

//--- rtl/swsc_top.sv
// Switch status and micro-step sequencer configuration register bank.
`default_nettype none
module swsc_top
(
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // Register access port
    input wire swsc_pkg::swsc_req_s REG_REQ_I,
    output swsc_pkg::swsc_rsp_s REG_RSP_O,
    // Reference switch pins and switch configuration
    input wire logic STOP_L_PIN_I,
    input wire logic STOP_R_PIN_I,
    input wire logic POL_L_I,
    input wire logic POL_R_I,
    input wire logic STOP_EN_L_I,
    input wire logic STOP_EN_R_I,
    input wire logic LATCH_L_ACT_I,
    input wire logic LATCH_L_INACT_I,
    input wire logic LATCH_R_ACT_I,
    input wire logic LATCH_R_INACT_I,
    input wire logic [31:0] RAMP_POS_I,
    output logic [31:0] LATCH_POS_O,
    // Driver feedback
    input wire logic STALL_EVENT_I,
    input wire logic [2:0] STALL_VALUE_I,
    input wire logic [2:0] DRV_STATUS_I,
    output logic [2:0] STALL_THRESHOLD_O,
    // Sequencer
    input wire logic STEP_I,
    input wire logic DIR_I,
    input wire logic STANDBY_I,
    input wire logic [11:0] TABLE_AMP_I,
    output logic [12:0] MSTEP_IDX_O,
    output logic [11:0] COIL_AMP_O,
    output logic COIL_EN_O,
    output logic DECAY_MIX_O,
    output logic [4:0] RUN_CURRENT_O,
    output logic [4:0] IDLE_CURRENT_O,
    output logic RUN_DECAY_MIX_O,
    output logic IDLE_DECAY_MIX_O,
    // Chopper clock
    output logic CHOP_CLK_O
);
    import swsc_pkg::*;

    logic [1:0] sw_sync;
    logic [1:0] sw_prev_reg;
    logic [2:0] warm_reg;
    logic [1:0] sw_active;
    logic [2:0] flag_reg;
    logic [31:0] latch_reg;
    logic [8:0] seq_reg;
    logic [23:0] coil_reg;
    logic [2:0] thr_reg;
    logic [10:0] div_reg;
    logic [10:0] div_cnt_reg;
    logic chop_reg;
    logic [12:0] idx_reg;
    logic [11:0] amp_reg;
    logic en_reg;
    logic mix_reg;
    logic valid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] live_reg;
    logic [1:0] stop_reg;
    logic [2:0] stall_val_reg;
    logic [2:0] drv_reg;
    logic cap_l;
    logic cap_r;
    logic wr;
    logic rd_status;
    logic [4:0] cur_sel;

    // Stride through the full table so that each length spans one period.
    function automatic logic [12:0] len_stride(input logic [1:0] code);
        case (code)
            LEN_8192: len_stride = 13'h0001;
            LEN_4096: len_stride = 13'h0002;
            LEN_8: len_stride = 13'h0400;
            LEN_4: len_stride = 13'h0800;
            default: len_stride = 13'h0001;
        endcase
    endfunction

    // Scales above full amplitude are held at full to avoid table overflow.
    function automatic logic [11:0] scale_amp(input logic [11:0] amp,
                                              input logic [4:0] cur);
        logic [16:0] prod;
        logic [4:0] c;
        prod = 17'h00000;
        c = (cur > CUR_FULL) ? CUR_FULL : cur;
        prod = amp * c;
        scale_amp = prod[15:4];
    endfunction

    swsc_sync u_sync
    (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .ce_i(CE_I),
        .async_i({STOP_R_PIN_I, STOP_L_PIN_I}),
        .sync_o(sw_sync)
    );

    assign sw_active = sw_sync ^ {POL_R_I, POL_L_I};
    assign cap_l = warm_reg[2] &&
                   ((LATCH_L_ACT_I && sw_active[0] && !sw_prev_reg[0]) ||
                    (LATCH_L_INACT_I && !sw_active[0] && sw_prev_reg[0]));
    assign cap_r = warm_reg[2] &&
                   ((LATCH_R_ACT_I && sw_active[1] && !sw_prev_reg[1]) ||
                    (LATCH_R_INACT_I && !sw_active[1] && sw_prev_reg[1]));
    assign wr = REG_REQ_I.wr;
    assign rd_status = REG_REQ_I.rd && (REG_REQ_I.addr == ADDR_SWITCH_STATE);
    assign cur_sel = STANDBY_I ? coil_reg[IDLE_CUR_LSB +: CUR_W]
                               : coil_reg[RUN_CUR_LSB +: CUR_W];

    // Live levels; captures wait three edges so reset values fake no edge.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            sw_prev_reg <= 2'h0;
            warm_reg <= 3'h0;
            live_reg <= 2'h0;
            stop_reg <= 2'h0;
        end
        else if (CE_I)
        begin
            sw_prev_reg <= sw_active;
            warm_reg <= {warm_reg[1:0], 1'b1};
            live_reg <= sw_active; // RULE1
            stop_reg <= sw_active & {STOP_EN_R_I, STOP_EN_L_I}; // RULE3
        end
    end

    // Sticky flags: a new event in the reading cycle survives the clear.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            flag_reg <= 3'h0;
        end
        else if (CE_I)
        begin
            flag_reg[0] <= cap_l || (flag_reg[0] && !rd_status); // RULE2 RULE14
            flag_reg[1] <= cap_r || (flag_reg[1] && !rd_status); // RULE2
            flag_reg[2] <= STALL_EVENT_I || (flag_reg[2] && !rd_status); // RULE4
        end
    end

    // One latch register is shared, so the latest capture on either side overwrites it.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            latch_reg <= 32'h00000000;
        end
        else if (CE_I && (cap_l || cap_r))
        begin
            latch_reg <= RAMP_POS_I; // RULE14
        end
    end

    // Host writes; reserved addresses simply match no case.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            seq_reg <= SEQ_RESET;
            coil_reg <= COIL_RESET;
            thr_reg <= THR_RESET;
            div_reg <= DIV_RESET; // RULE12
        end
        else if (CE_I && wr)
        begin
            case (REG_REQ_I.addr)
                ADDR_SEQ_CONFIG: seq_reg <= REG_REQ_I.wdata[SEQ_W-1:0]; // RULE5
                ADDR_COIL_SCALE:
                begin
                    coil_reg <= REG_REQ_I.wdata[COIL_W-1:0]; // RULE8
                    thr_reg <= REG_REQ_I.wdata[THR_LSB +: THR_W]; // RULE9
                end
                ADDR_CHOP_DIV:
                begin
                    if (REG_REQ_I.wdata[DIV_W-1:0] < DIV_MIN)
                        div_reg <= DIV_MIN; // RULE11
                    else
                        div_reg <= REG_REQ_I.wdata[DIV_W-1:0];
                end
                default: ; // RULE15
            endcase
        end
    end

    // Read port answers one cycle after the strobe.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            valid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            stall_val_reg <= 3'h0;
            drv_reg <= 3'h0;
        end
        else if (CE_I)
        begin
            stall_val_reg <= STALL_VALUE_I; // RULE9
            drv_reg <= DRV_STATUS_I; // RULE10
            valid_reg <= REG_REQ_I.rd;
            rdata_reg <= 32'h00000000;
            if (REG_REQ_I.rd)
            begin
                case (REG_REQ_I.addr)
                    ADDR_SWITCH_STATE:
                        rdata_reg <= {25'h0000000, flag_reg[2], stop_reg,
                                      flag_reg[1:0], live_reg}; // RULE1 RULE3
                    ADDR_SEQ_CONFIG: rdata_reg <= {23'h000000, seq_reg};
                    ADDR_STALL_READ: rdata_reg <= {29'h00000000, stall_val_reg};
                    ADDR_DRV_FLAGS: rdata_reg <= {29'h00000000, drv_reg}; // RULE10
                    default: rdata_reg <= 32'h00000000; // RULE15
                endcase
            end
        end
    end

    // Micro-step index.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            idx_reg <= 13'h0000;
        end
        else if (CE_I && STEP_I && !seq_reg[SEQ_HALT_BIT]) // RULE7
        begin
            if (DIR_I)
                idx_reg <= idx_reg - len_stride(seq_reg[1:0]); // RULE6
            else
                idx_reg <= idx_reg + len_stride(seq_reg[1:0]); // RULE6
        end
    end

    // Coil amplitude, enable and decay selection.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            amp_reg <= 12'h000;
            en_reg <= 1'b0;
            mix_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            amp_reg <= scale_amp(TABLE_AMP_I, cur_sel); // RULE13
            en_reg <= (cur_sel != 5'h00); // RULE13
            mix_reg <= STANDBY_I ? coil_reg[IDLE_MIX_BIT]
                                 : coil_reg[RUN_MIX_BIT]; // RULE8
        end
    end

    // Chopper clock toggles every divider count, so its period is twice it.
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            div_cnt_reg <= 11'h000;
            chop_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            if (div_cnt_reg >= div_reg - 11'h001)
            begin
                div_cnt_reg <= 11'h000;
                chop_reg <= !chop_reg; // RULE12
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg + 11'h001;
            end
        end
    end

    assign REG_RSP_O = {valid_reg, rdata_reg};
    assign LATCH_POS_O = latch_reg;
    assign STALL_THRESHOLD_O = thr_reg;
    assign MSTEP_IDX_O = idx_reg;
    assign COIL_AMP_O = amp_reg;
    assign COIL_EN_O = en_reg;
    assign DECAY_MIX_O = mix_reg;
    assign RUN_CURRENT_O = coil_reg[RUN_CUR_LSB +: CUR_W];
    assign IDLE_CURRENT_O = coil_reg[IDLE_CUR_LSB +: CUR_W];
    assign RUN_DECAY_MIX_O = coil_reg[RUN_MIX_BIT];
    assign IDLE_DECAY_MIX_O = coil_reg[IDLE_MIX_BIT];
    assign CHOP_CLK_O = chop_reg;
endmodule
`default_nettype wire

//--- tb/swsc_host.sv
// Host model that issues register requests to the bank.
`default_nettype none
module swsc_host
(
    // Clock
    input wire logic clk_i,
    // Register port
    output swsc_pkg::swsc_req_s req_o,
    input wire swsc_pkg::swsc_rsp_s rsp_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import swsc_pkg::*;
    initial req_o = '0;
    // Released lines carry inverted values so stale data never looks valid.
    task automatic access(input logic w, input logic [6:0] a,
        input logic [31:0] d, input int n, output logic [31:0] q);
        @(posedge clk_i);
        #1;
        req_o = {w, !w, a, d};
        @(posedge clk_i);
        #1;
        q = rsp_i.valid ? rsp_i.rdata : 32'hFFFFFFFF;
        for (int i = 1; i < n; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        req_o = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

//--- tb/swsc_monitor.sv
// Concurrent checks on the ports of the switch and sequencer bank.
`default_nettype none
module swsc_monitor
(
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // Register port
    input wire swsc_pkg::swsc_req_s REG_REQ_I,
    input wire swsc_pkg::swsc_rsp_s REG_RSP_O,
    // Driver feedback
    input wire logic STALL_EVENT_I,
    input wire logic [2:0] STALL_VALUE_I,
    input wire logic [2:0] DRV_STATUS_I,
    input wire logic [2:0] STALL_THRESHOLD_O,
    // Coil and chopper
    input wire logic STANDBY_I,
    input wire logic [11:0] TABLE_AMP_I,
    input wire logic [11:0] COIL_AMP_O,
    input wire logic COIL_EN_O,
    input wire logic [4:0] RUN_CURRENT_O,
    input wire logic [4:0] IDLE_CURRENT_O,
    input wire logic CHOP_CLK_O
);
    timeunit 1ns;
    timeprecision 100ps;
    import swsc_pkg::*;
    logic [4:0] sel;
    assign sel = STANDBY_I ? IDLE_CURRENT_O : RUN_CURRENT_O;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    sequence s_rd(a);
        CE_I && REG_REQ_I.rd && REG_REQ_I.addr == a;
    endsequence
    sequence s_stall_rd;
        CE_I && STALL_EVENT_I ##1 CE_I && !REG_REQ_I.rd
            ##1 s_rd(ADDR_SWITCH_STATE);
    endsequence
    sequence s_two_rd;
        s_rd(ADDR_SWITCH_STATE) ##0 !STALL_EVENT_I ##1 s_rd(ADDR_SWITCH_STATE);
    endsequence
    property p_stall_val;
        s_rd(ADDR_STALL_READ) |=> REG_RSP_O == {1'b1, 29'h0,
            $past(STALL_VALUE_I, 2)};
    endproperty
    a_stall_val: assert property (p_stall_val) else $error("stall value");
    property p_drv;
        s_rd(ADDR_DRV_FLAGS) |=> REG_RSP_O == {1'b1, 29'h0,
            $past(DRV_STATUS_I, 2)};
    endproperty
    a_drv: assert property (p_drv) else $error("driver flags");
    property p_stall_set;
        s_stall_rd |=> REG_RSP_O.valid && REG_RSP_O.rdata[SW_STALL];
    endproperty
    a_stall_set: assert property (p_stall_set) else $error("stall unset");
    property p_stall_clr;
        s_two_rd |=> REG_RSP_O.valid && !REG_RSP_O.rdata[SW_STALL];
    endproperty
    a_stall_clr: assert property (p_stall_clr) else $error("stall kept");
    property p_thr;
        CE_I && REG_REQ_I.wr && REG_REQ_I.addr == ADDR_COIL_SCALE
            |=> STALL_THRESHOLD_O == $past(REG_REQ_I.wdata[18:16]);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold");
    property p_full;
        CE_I && sel == CUR_FULL |=> COIL_AMP_O == $past(TABLE_AMP_I);
    endproperty
    a_full: assert property (p_full) else $error("full scale");
    property p_off;
        CE_I && sel == 5'h0 |=> !COIL_EN_O;
    endproperty
    a_off: assert property (p_off) else $error("coil enabled");
    // Any divider at or above the floor keeps the level for many cycles.
    property p_chop;
        CE_I && $changed(CHOP_CLK_O) |=> $stable(CHOP_CLK_O)[*8];
    endproperty
    a_chop: assert property (p_chop) else $error("chopper too fast");
endmodule
bind swsc_top swsc_monitor u_mon (.*);
`default_nettype wire

//--- tb/swsc_top_tb.sv
// Self-checking testbench for the switch and sequencer bank.
`default_nettype none
module swsc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import swsc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, sl = 1'b0, sr = 1'b0;
    logic pl = 1'b0, el = 1'b1, la = 1'b1, sev = 1'b0, stb = 1'b0;
    logic dir = 1'b0, stby = 1'b0, cen, mix, rmix, imix, chop;
    logic [31:0] ramp = 32'h12345678, lpos, q;
    logic [2:0] sval = 3'h5, drv = 3'h6, thr;
    logic [11:0] tamp = 12'h800, camp;
    logic [12:0] idx;
    logic [4:0] rcur, icur;
    swsc_req_s req;
    swsc_rsp_s rsp;
    int failures = 0, checks = 0;
    swsc_host u_host (.clk_i(clk), .req_o(req), .rsp_i(rsp));
    swsc_top dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .REG_REQ_I(req),
        .REG_RSP_O(rsp), .STOP_L_PIN_I(sl), .STOP_R_PIN_I(sr),
        .POL_L_I(pl), .POL_R_I(1'b0), .STOP_EN_L_I(el), .STOP_EN_R_I(el),
        .LATCH_L_ACT_I(la), .LATCH_L_INACT_I(1'b0), .LATCH_R_ACT_I(la),
        .LATCH_R_INACT_I(1'b0), .RAMP_POS_I(ramp), .LATCH_POS_O(lpos),
        .STALL_EVENT_I(sev), .STALL_VALUE_I(sval), .DRV_STATUS_I(drv),
        .STALL_THRESHOLD_O(thr), .STEP_I(stb), .DIR_I(dir),
        .STANDBY_I(stby), .TABLE_AMP_I(tamp), .MSTEP_IDX_O(idx),
        .COIL_AMP_O(camp), .COIL_EN_O(cen), .DECAY_MIX_O(mix),
        .RUN_CURRENT_O(rcur), .IDLE_CURRENT_O(icur),
        .RUN_DECAY_MIX_O(rmix), .IDLE_DECAY_MIX_O(imix), .CHOP_CLK_O(chop));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        u_host.access(1'b1, a, d, 1, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        u_host.access(1'b0, a, 32'h0, 1, q);
        chk(q, e);
    endtask
    task automatic step1();
        stb = 1'b1;
        cyc(1);
        stb = 1'b0;
        cyc(2);
    endtask
    // Skips the partial gap so a divider change mid-count is not measured.
    task automatic chop_gap(output int n);
        logic c;
        c = chop;
        for (n = 0; n < 3000 && chop == c; n++) cyc(1);
        c = chop;
        for (n = 0; n < 3000 && chop == c; n++) cyc(1);
    endtask
    task automatic t_reset();
        int n;
        rd(ADDR_SEQ_CONFIG, 32'h0);
        chk(rcur, 32'h10);
        chk({imix, rmix, icur}, 32'h20);
        chop_gap(n);
        chk(n, 32'h280);
        $display("reset test done");
    endtask
    task automatic t_seq();
        logic [12:0] st [4] = '{13'h1, 13'h2, 13'h400, 13'h800};
        logic [12:0] p;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_SEQ_CONFIG, 32'(c));
            rd(ADDR_SEQ_CONFIG, 32'(c));
            p = idx;
            step1();
            chk(idx, 13'(p + st[c]));
            wr(ADDR_SEQ_CONFIG, 32'h100 | 32'(c));
            p = idx;
            step1();
            chk(idx, p);
        end
        wr(ADDR_SEQ_CONFIG, 32'h3);
        dir = 1'b1;
        p = idx;
        step1();
        chk(idx, 13'(p - 13'h800));
        ce = 1'b0;
        p = idx;
        step1();
        chk(idx, p);
        ce = 1'b1;
        dir = 1'b0;
        $display("sequencer test done");
    endtask
    task automatic t_coil();
        wr(ADDR_COIL_SCALE, 32'h00058408);
        rd(ADDR_COIL_SCALE, 32'h0);
        chk({imix, icur, rmix, rcur}, 32'h908);
        chk(thr, 32'h5);
        chk(camp, 32'h400);
        stby = 1'b1;
        cyc(2);
        chk({mix, camp}, 32'h1200);
        wr(ADDR_COIL_SCALE, 32'h00000010);
        cyc(2);
        chk(cen, 32'h0);
        stby = 1'b0;
        cyc(2);
        chk({cen, camp}, 32'h1800);
        $display("coil test done");
    endtask
    task automatic t_switch();
        rd(ADDR_STALL_READ, 32'h5);
        rd(ADDR_DRV_FLAGS, 32'h6);
        sl = 1'b1;
        cyc(6);
        rd(ADDR_SWITCH_STATE, 32'h15);
        chk(lpos, 32'h12345678);
        rd(ADDR_SWITCH_STATE, 32'h11);
        sev = 1'b1;
        cyc(1);
        sev = 1'b0;
        u_host.access(1'b0, ADDR_SWITCH_STATE, 32'h0, 2, q);
        chk(q, 32'h51);
        rd(ADDR_SWITCH_STATE, 32'h11);
        ramp = 32'h0000ABCD;
        sr = 1'b1;
        cyc(6);
        rd(ADDR_SWITCH_STATE, 32'h3B);
        chk(lpos, 32'h0000ABCD);
        sr = 1'b0;
        cyc(6);
        sl = 1'b0;
        cyc(6);
        rd(ADDR_SWITCH_STATE, 32'h0);
        pl = 1'b1;
        cyc(6);
        rd(ADDR_SWITCH_STATE, 32'h15);
        pl = 1'b0;
        cyc(6);
        rd(ADDR_SWITCH_STATE, 32'h0);
        $display("switch test done");
    endtask
    task automatic t_div();
        int n;
        wr(ADDR_CHOP_DIV, 32'hA);
        chop_gap(n);
        chk(n, 32'h60);
        wr(ADDR_CHOP_DIV, 32'hC8);
        chop_gap(n);
        chk(n, 32'hC8);
        rd(ADDR_CHOP_DIV, 32'h0);
        $display("divider test done");
    endtask
    task automatic t_rsvd();
        logic [6:0] a [6] = '{7'h50, 7'h51, 7'h52, 7'h53, 7'h58, 7'h7F};
        foreach (a[i])
        begin
            wr(a[i], 32'hFFFFFFFF);
            rd(a[i], 32'h0);
        end
        rd(ADDR_SEQ_CONFIG, 32'h3);
        $display("reserved test done");
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        cyc(12);
        rstn = 1'b1;
        t_reset();
        t_seq();
        t_coil();
        t_switch();
        t_div();
        t_rsvd();
        complete_run();
    end
    initial
    begin
        #100us;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
